// file: i2c_slv_pkg.sv
// Operation
// (R1) After START, shift in seven address bits MSB first and compare with own address.
// (R2) On address equality set the address-match flag and raise the interrupt.
// (R3) Capture the eighth bit after START into the read/write flag.
// (R4) On address match pull SDA low during the ninth clock.
// (R5) Detect START as SDA falling while SCL high and set bus-busy.
// (R6) Data bytes are eight bits, MSB first, only after address acknowledge.
// (R7) As receiver drive the transmit-acknowledge bit on SDA at the ninth clock.
// (R8) As transmitter on master not-acknowledge, release SDA and wait for STOP.
// (R9) After address match hold SCL low until data write or dummy read.
// (R10) Software sets I2C slave mode and enable, loads address, enables interrupt.
// (R11) Software sets direction bit to follow the read/write flag after a match.
// (R12) One interrupt for address match, byte completion and bus time-out.
// (R13) Time-out counter starts on START plus match; each SCL fall clears it.
// (R14) Time-out fires if period passes before next SCL fall; STOP halts it.
// (R15) On overflow stop counter, clear enable, set flag, raise interrupt.
// (R16) On time-out reset slave logic and status register; others keep values.
// (R17) Time-out period is (select plus one) times 32 subsidiary clock periods.
// (R18) Time-out register: enable bit 7, flag bit 6, period bits 5..0, reset zero.
// (R19) Software writes each outgoing byte and reads each received byte via data register.
// (R20) Only the master makes START; it sends STOP when no slave acknowledges.
// (R21) Clear receive-acknowledge flag on master acknowledge, set it otherwise.
// (R22) Debounce SDA and SCL: none, two or four system clocks.
// (R23) On enable rising, reset status flags but keep direction and acknowledge bits.
// (R24) On address mismatch do not acknowledge and ignore the bus until next START.
package i2c_slv_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SUB_PERIOD_NS = 31250;
  localparam int SUB_DIV       = (SUB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TO_UNIT       = 32;

  localparam logic [2:0] OFS_MODE   = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_ADDR   = 3'h2;
  localparam logic [2:0] OFS_DATA   = 3'h3;
  localparam logic [2:0] OFS_TOC    = 3'h4;

  localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
  localparam logic [2:0] DEB_NONE       = 3'h0;
  localparam logic [2:0] DEB_TWO        = 3'h2;
  localparam logic [2:0] DEB_FOUR       = 3'h4;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] LAST_TX_BIT    = 4'h7;

  typedef struct packed {
    logic [2:0] mode;
    logic       rsv;
    logic [1:0] deb;
    logic       en;
    logic       ie;
  } mode_ctl_s;

  typedef struct packed {
    logic complete;
    logic match;
    logic busy;
    logic dir;
    logic txack;
    logic rw;
    logic wake;
    logic rxack;
  } status_s;

  typedef struct packed {
    logic       en;
    logic       flag;
    logic [5:0] sel;
  } to_ctl_s;

  localparam mode_ctl_s MODE_POR   = mode_ctl_s'(8'hE0);
  localparam status_s   STATUS_POR = status_s'(8'h81);
  localparam to_ctl_s   TOC_POR    = to_ctl_s'(8'h00);
  localparam logic [6:0] ADDR_POR  = 7'h00;
  localparam logic [7:0] DATA_POR  = 8'h00;

endpackage : i2c_slv_pkg

// file: line_filter.sv
`timescale 1ns/1ps
module line_filter (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] need_i,
  input  wire logic       line_i,
  output logic            line_o
);

  logic       meta_r;
  logic       sync_r;
  logic [2:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'h1;
      sync_r <= 1'h1;
    end else begin
      meta_r <= line_i;
      sync_r <= meta_r;
    end
  end

  // Glitches shorter than the window never reach the slave logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_o <= 1'h1;
      cnt_r  <= 3'h0;
    end else if (sync_r == line_o) begin
      cnt_r <= 3'h0;
    end else if (cnt_r >= need_i) begin
      line_o <= sync_r; // R22
      cnt_r  <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

endmodule : line_filter

// file: i2c_slave_timeout.sv
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module i2c_slave_timeout
  import i2c_slv_pkg::*;
#(
  parameter int SUB_DIV_P = SUB_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             irq_o
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_HOLD, ST_RX, ST_RX_ACK,
    ST_TX, ST_TX_ACK, ST_WAIT_STOP, ST_IGNORE
  } state_e;

  mode_ctl_s   mode_r;
  status_s     stat_r;
  to_ctl_s     toc_r;
  mode_ctl_s   wmode;
  status_s     wstat;
  to_ctl_s     wtoc;
  logic [6:0]  own_addr_r;
  logic [7:0]  data_r;
  state_e      state_r;
  logic [7:0]  shreg_r;
  logic [3:0]  bitcnt_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic        en_prev_r;
  logic        irq_r;
  logic [1:0]  pins;
  logic [1:0]  line_f;
  logic [2:0]  deb_need;
  logic        scl;
  logic        sda;
  logic        scl_prev_r;
  logic        sda_prev_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        active;
  logic        en_rise;
  logic        bus_req;
  logic [2:0]  idx;
  logic        wr_commit;
  logic        rd_commit;
  logic        data_wr;
  logic        data_rd;
  logic        release_hold;
  logic        addr_fall_ev;
  logic        addr_hit_ev;
  logic        byte_done;
  logic [11:0] sub_cnt_r;
  logic        sub_tick;
  logic        to_run_r;
  logic [11:0] to_cnt_r;
  logic [11:0] to_limit;
  logic        timeout;

  assign pins = {sda_i, scl_i};
  assign deb_need = (mode_r.deb == 2'h0) ? DEB_NONE :
                    (mode_r.deb == 2'h1) ? DEB_TWO : DEB_FOUR; // R22

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      line_filter u_filt (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .need_i (deb_need),
        .line_i (pins[g]),
        .line_o (line_f[g])
      );
    end
  endgenerate

  assign scl = line_f[0];
  assign sda = line_f[1];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_prev_r <= 1'h1;
      sda_prev_r <= 1'h1;
    end else begin
      scl_prev_r <= scl;
      sda_prev_r <= sda;
    end
  end

  assign scl_rise  = scl & ~scl_prev_r;
  assign scl_fall  = ~scl & scl_prev_r;
  assign start_det = ~sda & sda_prev_r & scl & scl_prev_r; // R5
  assign stop_det  = sda & ~sda_prev_r & scl & scl_prev_r;
  assign active    = mode_r.en && (mode_r.mode == MODE_I2C_SLAVE);
  assign en_rise   = mode_r.en & ~en_prev_r;

  // Wishbone slave: ack one cycle after the request, writes with wb_sel_i[0] set commit on the ack edge
  assign bus_req   = wb_cyc_i & wb_stb_i;
  assign idx       = wb_adr_i[4:2];
  assign wr_commit = bus_req & wb_we_i & ack_r & wb_sel_i[0];
  assign rd_commit = bus_req & ~wb_we_i & ack_r;
  assign data_wr   = wr_commit && (idx == OFS_DATA);
  assign data_rd   = rd_commit && (idx == OFS_DATA);
  assign wmode     = mode_ctl_s'(wb_dat_i[7:0]);
  assign wstat     = status_s'(wb_dat_i[7:0]);
  assign wtoc      = to_ctl_s'(wb_dat_i[7:0]);
  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = rdat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'h0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req & ~ack_r) begin
        case (idx)
          OFS_MODE:   rdat_r <= {24'h00_0000, mode_r};
          OFS_STATUS: rdat_r <= {24'h00_0000, stat_r};
          OFS_ADDR:   rdat_r <= {24'h00_0000, own_addr_r, 1'h0};
          OFS_DATA:   rdat_r <= {24'h00_0000, data_r};
          OFS_TOC:    rdat_r <= {24'h00_0000, toc_r};
          default:    rdat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r     <= MODE_POR;
      own_addr_r <= ADDR_POR;
      en_prev_r  <= 1'h0;
    end else begin
      en_prev_r <= mode_r.en;
      if (wr_commit && (idx == OFS_MODE)) begin
        mode_r     <= wmode;
        mode_r.rsv <= 1'h0;
      end
      if (wr_commit && (idx == OFS_ADDR)) begin
        own_addr_r <= wb_dat_i[7:1];
      end
    end
  end

  // Released SCL after software wrote the data register as transmitter or read it as receiver, or on a time-out
  assign release_hold = (state_r == ST_HOLD) &&
                        ((data_wr && stat_r.dir) || (data_rd && !stat_r.dir)); // R9
  assign addr_fall_ev = (state_r == ST_ADDR) && scl_fall && (bitcnt_r == BITS_PER_BYTE);
  assign addr_hit_ev  = addr_fall_ev && (shreg_r[7:1] == own_addr_r); // R1
  assign byte_done    = ((state_r == ST_RX_ACK) || (state_r == ST_TX_ACK)) && scl_fall;

  always_ff @(posedge clk_i) begin
    if (rst_i || !active || timeout) begin
      state_r  <= ST_IDLE; // R16
      shreg_r  <= 8'h00;
      bitcnt_r <= 4'h0;
    end else if (start_det) begin
      state_r  <= ST_ADDR;
      bitcnt_r <= 4'h0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shreg_r  <= {shreg_r[6:0], sda}; // R1 R6
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && (bitcnt_r == BITS_PER_BYTE)) begin
            bitcnt_r <= 4'h0;
            if (state_r == ST_RX) begin
              state_r <= ST_RX_ACK;
            end else if (addr_hit_ev) begin
              state_r <= ST_ADDR_ACK;
            end else begin
              state_r <= ST_IGNORE; // R24
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          if (scl_fall) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (release_hold) begin
            if (stat_r.dir) begin
              state_r <= ST_TX;
              shreg_r <= wb_dat_i[7:0];
            end else begin
              state_r <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            shreg_r <= {shreg_r[6:0], 1'h0}; // R6
            if (bitcnt_r == LAST_TX_BIT) begin
              bitcnt_r <= 4'h0;
              state_r  <= ST_TX_ACK;
            end else begin
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_fall) begin
            state_r <= stat_r.rxack ? ST_WAIT_STOP : ST_HOLD; // R8
          end
        end
        default: state_r <= state_r;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_r <= DATA_POR;
    end else if ((state_r == ST_RX) && scl_fall && (bitcnt_r == BITS_PER_BYTE)) begin
      data_r <= shreg_r;
    end else if (data_wr) begin
      data_r <= wb_dat_i[7:0];
    end
  end

  // Hardware events are applied last so they win over a same-cycle write
  always_ff @(posedge clk_i) begin
    if (rst_i || timeout) begin
      stat_r <= STATUS_POR; // R16
    end else begin
      if (en_rise) begin
        stat_r.complete <= 1'h1; // R23
        stat_r.match    <= 1'h0;
        stat_r.busy     <= 1'h0;
        stat_r.rw       <= 1'h0;
        stat_r.rxack    <= 1'h1;
      end
      if (wr_commit && (idx == OFS_STATUS)) begin
        stat_r.dir   <= wstat.dir;
        stat_r.txack <= wstat.txack;
        stat_r.wake  <= wstat.wake;
      end
      if (active && start_det) begin
        stat_r.busy     <= 1'h1; // R5
        stat_r.complete <= 1'h0;
        stat_r.match    <= 1'h0;
      end
      if (stop_det) begin
        stat_r.busy <= 1'h0;
      end
      if (addr_fall_ev) begin
        stat_r.rw <= shreg_r[0]; // R3
      end
      if (addr_hit_ev) begin
        stat_r.match <= 1'h1; // R2
      end
      if (release_hold) begin
        stat_r.complete <= 1'h0;
        stat_r.match    <= 1'h0;
      end
      if (byte_done) begin
        stat_r.complete <= 1'h1;
      end
      if ((state_r == ST_TX_ACK) && scl_rise) begin
        stat_r.rxack <= sda; // R21
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sub_tick) begin
      sub_cnt_r <= 12'h000;
    end else begin
      sub_cnt_r <= sub_cnt_r + 12'h001;
    end
  end

  assign sub_tick = (sub_cnt_r == 12'(SUB_DIV_P - 1));
  assign to_limit = 12'(({6'h00, toc_r.sel} + 12'h001) * TO_UNIT); // R17
  assign timeout  = to_run_r && toc_r.en && (to_cnt_r == to_limit); // R14

  always_ff @(posedge clk_i) begin
    if (rst_i || timeout || stop_det || !active) begin
      to_run_r <= 1'h0; // R14 R15
    end else if (addr_hit_ev) begin
      to_run_r <= 1'h1; // R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !to_run_r || scl_fall) begin
      to_cnt_r <= 12'h000; // R13
    end else if (sub_tick && toc_r.en) begin
      to_cnt_r <= to_cnt_r + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      toc_r <= TOC_POR;
    end else begin
      if (wr_commit && (idx == OFS_TOC)) begin
        toc_r <= wtoc; // R18
      end
      if (timeout) begin
        toc_r.en   <= 1'h0; // R15
        toc_r.flag <= 1'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'h0;
    end else begin
      irq_r <= mode_r.ie && (addr_hit_ev || byte_done || timeout); // R12
    end
  end

  assign irq_o    = irq_r;
  assign scl_o    = 1'h0;
  assign sda_o    = 1'h0;
  assign scl_oe_o = (state_r == ST_HOLD); // R9
  always_comb begin
    case (state_r)
      ST_ADDR_ACK: sda_oe_o = 1'h1; // R4
      ST_RX_ACK:   sda_oe_o = ~stat_r.txack; // R7
      ST_TX:       sda_oe_o = ~shreg_r[7];
      default:     sda_oe_o = 1'h0;
    endcase
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_start_busy: assert property (active && start_det && !timeout |=> stat_r.busy) // R5
    else $error("busy flag not set after start");
  a_match_flag: assert property (addr_hit_ev && !timeout
      |=> stat_r.match && state_r == ST_ADDR_ACK) // R2
    else $error("address match not flagged");
  a_match_irq: assert property (addr_hit_ev && mode_r.ie |=> irq_o) // R12
    else $error("no interrupt on address match");
  a_rw_capture: assert property (addr_fall_ev && !timeout |=> stat_r.rw == $past(shreg_r[0])) // R3
    else $error("read/write bit not captured");
  a_addr_ack: assert property (state_r == ST_ADDR_ACK |-> sda_oe_o) // R4
    else $error("address not acknowledged");
  a_rx_ackbit: assert property (state_r == ST_RX_ACK |-> sda_oe_o == !stat_r.txack) // R7
    else $error("wrong acknowledge driven");
  a_nack_release: assert property (state_r == ST_TX_ACK && scl_fall && stat_r.rxack && active
      && !timeout && !start_det && !stop_det |=> state_r == ST_WAIT_STOP && !sda_oe_o) // R8
    else $error("sda not released after nack");
  a_hold_stretch: assert property ($rose(state_r == ST_HOLD)
      |-> scl_oe_o && !sda_oe_o && (stat_r.match || stat_r.complete)) // R9
    else $error("scl not stretched");
  a_tx_msb: assert property (release_hold && stat_r.dir && active && !timeout
      |=> sda_oe_o == !$past(wb_dat_i[7])) // R6
    else $error("first bit is not msb");
  a_rxack_sample: assert property (state_r == ST_TX_ACK && scl_rise && active && !timeout
      && !start_det && !stop_det |=> stat_r.rxack == $past(sda)) // R21
    else $error("receive acknowledge not sampled");
  a_to_clear: assert property (to_run_r && scl_fall && !timeout && !stop_det && active
      |=> to_cnt_r == 12'h000) // R13
    else $error("time-out count not cleared");
  a_to_bound: assert property (to_run_r && toc_r.en |-> to_cnt_r <= to_limit) // R17
    else $error("time-out count passed period");
  a_stop_halt: assert property (stop_det |=> !to_run_r) // R14
    else $error("stop did not halt time-out");
  a_to_effects: assert property (timeout |=> !toc_r.en && toc_r.flag && stat_r == STATUS_POR
      && state_r == ST_IDLE) // R15 R16
    else $error("time-out effects missing");
  a_nomatch_quiet: assert property (state_r == ST_IGNORE |-> !sda_oe_o && !scl_oe_o) // R24
    else $error("bus driven after mismatch");
  a_en_rise: assert property (en_rise && !timeout && !start_det
      |=> stat_r.complete && !stat_r.match && !stat_r.busy) // R23
    else $error("flags not reset on enable");

  c_match: cover property (addr_hit_ev);
  c_rx_byte: cover property (state_r == ST_RX_ACK && scl_fall);
  c_tx_nack: cover property (state_r == ST_WAIT_STOP);
  c_timeout: cover property (timeout);

endmodule : i2c_slave_timeout

// file: i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int HP = 8
) (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Each phase outlasts the slave's widest debounce window, so no level is lost
  int hung;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    hung  = 0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  // Released SCL may be held low by the slave, so wait for the wire itself
  task automatic rise();
    int k;
    scl_o <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (scl_i !== 1'b1 && k < 5000);
    if (k >= 5000) hung++;
    idle(HP - 1);
  endtask : rise

  task automatic bit_out(input logic b);
    sda_o <= b;
    idle(HP);
    rise();
    scl_o <= 1'b0;
  endtask : bit_out

  task automatic bit_in(output logic b);
    sda_o <= 1'b1;
    idle(HP);
    rise();
    b = sda_i;
    scl_o <= 1'b0;
  endtask : bit_in

  // Only this side makes START and STOP
  task automatic start_cond();
    sda_o <= 1'b1;
    idle(HP);
    rise();
    sda_o <= 1'b0;
    idle(HP);
    scl_o <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    sda_o <= 1'b0;
    idle(HP);
    rise();
    sda_o <= 1'b1;
    idle(HP);
  endtask : stop_cond

  task automatic write_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(ack);
    // The slave sees the last fall only after its filter delay
    idle(12);
  endtask : write_byte

  task automatic read_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(ack);
    idle(2);
    sda_o <= 1'b1;
    idle(12);
  endtask : read_byte
endmodule : i2c_master_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import i2c_slv_pkg::*;
  localparam int SUBD = 2;
  typedef struct {string nm; logic [7:0] v;} exp_s;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [4:0]  wb_adr_i = '0;
  logic [3:0]  wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic        wb_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, ak, bad;
  wire         m_scl, m_sda;
  logic [6:0]  own;
  logic [1:0]  deb;
  logic [7:0]  d0, d1, t0, t1, got, mode_v;
  int          err_total = 0, cmp_count = 0, irq_cnt = 0, n;
  exp_s        exp_q[$];
  // Open-drain wires with pull-ups
  wire scl_w = m_scl & (scl_oe_o ? scl_o : 1'b1);
  wire sda_w = m_sda & (sda_oe_o ? sda_o : 1'b1);

  i2c_slave_timeout #(.SUB_DIV_P(SUBD)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w), .sda_i(sda_w),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
  i2c_master_model u_mst (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w),
    .scl_o(m_scl), .sda_o(m_sda));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (irq_o === 1'b1) irq_cnt++;

  task automatic complete_run();
    $display("Checks %0d, errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Read results are compared when the acknowledge shows them
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      exp_s e;
      e = exp_q.pop_front();
      chk(e.nm, e.v, wb_dat_o[7:0]);
    end
    if (u_mst.hung != 0) begin
      err_total++;
      $display("ERROR clock stretch wait ran out");
      complete_run();
    end
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    complete_run();
  end

  task automatic xfer(input logic [4:0] a, input logic we, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1 | 4'($urandom & 32'hE);
    wb_dat_i <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) begin
      err_total++;
      $display("ERROR bus acknowledge missing");
      complete_run();
    end
  endtask : xfer

  task automatic wr(input logic [2:0] o, input logic [7:0] d);
    xfer({o, 2'b00}, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [2:0] o, input logic [7:0] e, input string nm);
    exp_q.push_back('{nm, e});
    xfer({o, 2'b00}, 1'b0, 8'h00);
  endtask : rd

  initial begin
    void'($urandom(20347));
    own = 7'($urandom);
    deb = 2'($urandom);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    t0 = 8'($urandom);
    t1 = 8'($urandom);
    mode_v = {MODE_I2C_SLAVE, 1'b0, deb, 2'b11};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_MODE, 8'hE0, "mode reset");
    rd(OFS_STATUS, 8'h81, "status reset");
    rd(OFS_TOC, 8'h00, "timeout reset");
    xfer(5'h1C, 1'b1, 8'hFF);
    rd(3'h7, 8'h00, "unmapped");
    wr(OFS_MODE, mode_v);
    wr(OFS_ADDR, {own, 1'b0});
    rd(OFS_ADDR, {own, 1'b0}, "own address");
    wr(OFS_TOC, 8'h81);
    // Slave receives two bytes, second one refused by its acknowledge bit
    u_mst.start_cond();
    u_mst.write_byte({own, 1'b0}, ak);
    chk("address ack", 8'h00, {7'h0, ak});
    u_mst.idle(3);
    chk("match irq", 8'h01, 8'(irq_cnt));
    rd(OFS_STATUS, 8'h61, "status after match");
    chk("stretch after match", 8'h01, {7'h0, scl_oe_o});
    wr(OFS_STATUS, 8'h00);
    xfer({OFS_DATA, 2'b00}, 1'b0, 8'h00);
    u_mst.write_byte(d0, ak);
    chk("data ack", 8'h00, {7'h0, ak});
    rd(OFS_STATUS, 8'hA1, "status after byte");
    wr(OFS_STATUS, 8'h08);
    rd(OFS_DATA, d0, "received byte");
    u_mst.write_byte(d1, ak);
    chk("refused ack", 8'h01, {7'h0, ak});
    rd(OFS_DATA, d1, "second byte");
    u_mst.stop_cond();
    u_mst.idle(300);
    rd(OFS_TOC, 8'h81, "no timeout while clocked");
    rd(OFS_STATUS, 8'h09, "status after stop");
    chk("irq count write", 8'h03, 8'(irq_cnt));
    // Slave transmits two bytes, master refuses the second
    u_mst.start_cond();
    u_mst.write_byte({own, 1'b1}, ak);
    chk("read address ack", 8'h00, {7'h0, ak});
    rd(OFS_STATUS, 8'h6D, "status read request");
    wr(OFS_STATUS, 8'h10);
    chk("stretch before load", 8'h01, {7'h0, scl_oe_o});
    wr(OFS_DATA, t0);
    u_mst.read_byte(got, 1'b0);
    chk("sent byte", t0, got);
    rd(OFS_STATUS, 8'hB4, "ack seen");
    wr(OFS_DATA, t1);
    u_mst.read_byte(got, 1'b1);
    chk("second sent byte", t1, got);
    rd(OFS_STATUS, 8'hB5, "nack seen");
    bad = 1'b0;
    repeat (50) @(posedge clk_i) if (sda_oe_o !== 1'b0) bad = 1'b1;
    chk("sda released", 8'h00, {7'h0, bad});
    u_mst.stop_cond();
    chk("irq count read", 8'h06, 8'(irq_cnt));
    // Enable rising keeps direction, transmit-acknowledge and wake bits only
    wr(OFS_STATUS, 8'h18);
    wr(OFS_MODE, mode_v & 8'hFD);
    wr(OFS_MODE, mode_v);
    rd(OFS_STATUS, 8'h99, "status after enable");
    wr(OFS_STATUS, 8'h00);
    // Foreign address is ignored
    u_mst.start_cond();
    u_mst.write_byte({own ^ 7'h01, 1'b0}, ak);
    chk("foreign ack", 8'h01, {7'h0, ak});
    u_mst.write_byte(d0, ak);
    chk("ignored byte", 8'h01, {7'h0, ak});
    chk("no stretch", 8'h00, {7'h0, scl_oe_o});
    u_mst.stop_cond();
    chk("no irq foreign", 8'h06, 8'(irq_cnt));
    // Bus held still after match until the period runs out
    u_mst.start_cond();
    u_mst.write_byte({own, 1'b0}, ak);
    chk("timeout address ack", 8'h00, {7'h0, ak});
    n = 0;
    while (irq_cnt < 8 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk("timeout period", 8'h01, {7'h0, n >= 118 && n <= 138});
    rd(OFS_TOC, 8'h41, "timeout control");
    rd(OFS_STATUS, 8'h81, "status after timeout");
    rd(OFS_MODE, mode_v, "mode kept");
    rd(OFS_ADDR, {own, 1'b0}, "address kept");
    chk("stretch dropped", 8'h00, {7'h0, scl_oe_o});
    u_mst.stop_cond();
    wr(OFS_TOC, 8'h7F);
    rd(OFS_TOC, 8'h7F, "timeout fields");
    wr(OFS_TOC, 8'h01);
    rd(OFS_TOC, 8'h01, "flag cleared");
    u_mst.idle(5);
    complete_run();
  end
endmodule : tb
